// file: src/osp_cmd.sv
// otp and sector protection command handling of a serial flash
// assumes pins arrive asynchronously; sck well below clock_i / 4
//
// Behaviour
// - opcode 42h programs the separate 1024-byte one-time region
// - write enable command sets the latch needed before any write
// - zeros into a locked one-time region fail and set program error
// - only still-erased one-time bits change; ones leave bits alone
// - opcode 4Bh reads one-time region without wrap; past end undefined
// - one-time read always has exactly one dummy byte
// - opcode 2Bh shifts protection mode register out lsb first
// - protection mode register repeats every 16 clocks while selected
// - opcode 2Fh runs only if select rises after sixteenth data bit
// - writes start on select rise, one-time bytes as shifted in; busy flag set, latch cleared after
// - mode and sector bit writes set busy like program but never set program error
// - opcode E0h returns the sector volatile byte repeating every 8
// - opcode E1h runs only if select rises right after data byte
// - opcode E2h returns the sector persistent byte, repeating
// - opcode E3h runs only if select rises right after address
// - opcode E4h erases all persistent bits to one, exact framing
// - erase suspend is refused during persistent bulk erase
// - status reads are still served while an operation is busy
`timescale 1ns/10ps
module osp_cmd
	import osp_pkg::*;
#(
	parameter int SECTOR_COUNT = 256,
	parameter int SECTOR_SHIFT = 18,
	parameter int PROG_CYCLES  = PROG_CYCLES_DEF,
	parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	// serial pins
	input  wire logic        cs_n_i,
	input  wire logic        sck_i,
	input  wire logic        si_i,
	output logic             so_o,
	output logic             so_oe_n_o,
	// control from the rest of the chip
	input  wire logic        otp_locked_i,
	input  wire logic        p_err_clear_i,
	// status
	output logic             write_in_progress_flag_o,
	output logic             write_enable_latch_o,
	output logic             p_err_o,
	output logic             bulk_erasing_o,
	output logic             suspend_req_o,
	output logic             suspend_refused_o,
	output logic [15:0]      protection_mode_register_o
);

	localparam int SIDX_W = $clog2(SECTOR_COUNT);

	if (SECTOR_SHIFT + SIDX_W > SECT_ADDR_BITS || SIDX_W < 1 ||
		PROG_CYCLES < 2 || ERASE_CYCLES < 2 ||
		ERASE_CYCLES >= (1 << TIMER_BITS) ||
		PROG_CYCLES >= (1 << TIMER_BITS)) begin : g_bad_params
		$error("osp_cmd: unsupported parameter values");
	end

	// ==========================================================
	// pin synchronisers
	logic [1:0] cs_sync_q;
	logic [1:0] sck_sync_q;
	logic [1:0] si_sync_q;
	logic       cs_prev_q;
	logic       sck_prev_q;

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cs_sync_q  <= 2'h3;
			sck_sync_q <= 2'h0;
			si_sync_q  <= 2'h0;
			cs_prev_q  <= 1'b1;
			sck_prev_q <= 1'b0;
		end else begin
			cs_sync_q  <= {cs_sync_q[0], cs_n_i};
			sck_sync_q <= {sck_sync_q[0], sck_i};
			si_sync_q  <= {si_sync_q[0], si_i};
			cs_prev_q  <= cs_sync_q[1];
			sck_prev_q <= sck_sync_q[1];
		end
	end

	logic cs_n;
	logic si;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	assign cs_n     = cs_sync_q[1];
	assign si       = si_sync_q[1];
	assign sck_rise = !cs_n && sck_sync_q[1] && !sck_prev_q;
	assign sck_fall = !cs_n && !sck_sync_q[1] && sck_prev_q;
	assign cs_rise  = cs_n && !cs_prev_q;

	// ==========================================================
	// storage arrays
	logic [7:0] otp_mem  [OTP_BYTES];
	logic [7:0] vol_mem  [SECTOR_COUNT];
	logic [7:0] pers_mem [SECTOR_COUNT];

	logic                      otp_we;
	logic [OTP_INDEX_BITS-1:0] otp_waddr;
	logic [7:0]                otp_wdata;
	logic                      vol_we;
	logic [7:0]                vol_wdata;
	logic                      pers_we;
	logic                      pers_erase_all;
	logic [SIDX_W-1:0]         sect_idx;

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < OTP_BYTES; i++) begin
				otp_mem[i] <= OTP_ERASED;
			end
			for (int i = 0; i < SECTOR_COUNT; i++) begin
				vol_mem[i]  <= VOL_RESET;
				pers_mem[i] <= PERS_ERASED;
			end
		end else begin
			if (otp_we) begin
				otp_mem[otp_waddr] <= otp_wdata;
			end
			if (vol_we) begin
				vol_mem[sect_idx] <= vol_wdata;
			end
			if (pers_erase_all) begin
				for (int i = 0; i < SECTOR_COUNT; i++) begin
					pers_mem[i] <= PERS_ERASED;
				end
			end else if (pers_we) begin
				pers_mem[sect_idx] <= PERS_PROGRAMMED;
			end
		end
	end

	// ==========================================================
	// command state
	osp_state_type state_q, state_d;
	logic [5:0]            cnt_q, cnt_d;
	logic [31:0]           sh_q, sh_d;
	logic [7:0]            opc_q, opc_d;
	logic [31:0]           addr_q, addr_d;
	logic [15:0]           out_q, out_d;
	logic                  lsb_q, lsb_d;
	logic [2:0]            ocnt_q, ocnt_d;
	logic                  so_q, so_d;
	logic                  wel_q, wel_d;
	logic                  wip_q, wip_d;
	logic                  perr_q, perr_d;
	logic                  erasing_q, erasing_d;
	logic [TIMER_BITS-1:0] timer_q, timer_d;
	logic [15:0]           pmode_q, pmode_d;
	logic                  sreq_q, sreq_d;
	logic                  sref_q, sref_d;

	logic [31:0] shifted;
	logic [7:0]  op;
	logic [7:0]  sr;
	logic [7:0]  otp_old;
	logic [7:0]  otp_next;
	logic        start_op;
	logic        decode;
	logic        otp_byte_evt;

	assign shifted  = {sh_q[30:0], si};
	assign op       = shifted[7:0];
	assign decode   = sck_rise && state_q == ST_CMD &&
		cnt_q == 6'(CMD_BITS - 1);
	assign sect_idx = addr_q[SECTOR_SHIFT +: SIDX_W];
	assign otp_old  = otp_mem[addr_q[OTP_INDEX_BITS-1:0]];
	// reading past the region gives undefined data, never a wrap
	assign otp_next = (addr_q + 32'h1 < 32'(OTP_BYTES)) ?
		otp_mem[OTP_INDEX_BITS'(addr_q + 32'h1)] : OTP_UNDEFINED;

	always_comb begin
		sr = 8'h00;
		sr[SR_WIP_BIT]  = wip_q;
		sr[SR_WEL_BIT]  = wel_q;
		sr[SR_PERR_BIT] = perr_q;
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		opc_d = opc_q;
		addr_d = addr_q;
		out_d = out_q;
		lsb_d = lsb_q;
		ocnt_d = ocnt_q;
		so_d = so_q;
		wel_d = wel_q;
		wip_d = wip_q;
		perr_d = perr_q;
		erasing_d = erasing_q;
		timer_d = timer_q;
		pmode_d = pmode_q;
		sreq_d = 1'b0;
		sref_d = 1'b0;
		otp_we = 1'b0;
		otp_waddr = addr_q[OTP_INDEX_BITS-1:0];
		otp_wdata = otp_old;
		vol_we = 1'b0;
		vol_wdata = sh_q[7:0];
		pers_we = 1'b0;
		pers_erase_all = 1'b0;
		start_op = 1'b0;
		otp_byte_evt = 1'b0;

		if (p_err_clear_i) begin
			perr_d = 1'b0;
		end

		// self-timed operation
		if (wip_q) begin
			if (timer_q == '0) begin
				wip_d = 1'b0;
				wel_d = 1'b0;
				erasing_d = 1'b0;
				pers_erase_all = erasing_q;
			end else begin
				timer_d = timer_q - 1'b1;
			end
		end

		if (cs_n) begin
			state_d = ST_CMD;
			cnt_d = '0;
			// mode and sector writes commit only on an exactly framed select rise; one-time bytes commit per byte
			if (cs_rise && state_q == ST_DIN) begin
				case (opc_q)
					OPC_PMODE_PROGRAM: begin
						if (cnt_q == 6'(PMODE_BITS)) begin
							pmode_d = pmode_q & sh_q[31:16];
							start_op = 1'b1;
						end
					end
					OPC_VOL_WRITE: begin
						if (cnt_q == 6'(BYTE_BITS)) begin
							vol_we = 1'b1;
							start_op = 1'b1;
						end
					end
					OPC_PERS_PROGRAM: begin
						if (cnt_q == '0) begin
							pers_we = 1'b1;
							start_op = 1'b1;
						end
					end
					OPC_PERS_ERASE: begin
						if (cnt_q == '0) begin
							erasing_d = 1'b1;
							start_op = 1'b1;
						end
					end
					OPC_OTP_PROGRAM: begin
						start_op = (cnt_q == '0);
					end
					default: begin
						start_op = 1'b0;
					end
				endcase
				if (start_op) begin
					wip_d = 1'b1;
					timer_d = (opc_q == OPC_PERS_ERASE) ?
						TIMER_BITS'(ERASE_CYCLES - 1) :
						TIMER_BITS'(PROG_CYCLES - 1);
				end
			end
		end else if (sck_rise) begin
			case (state_q)
				ST_CMD: begin
					sh_d = shifted;
					cnt_d = cnt_q + 6'h1;
					if (decode) begin
						opc_d = op;
						cnt_d = '0;
						state_d = ST_IGNORE;
						if (op == OPC_STATUS_READ) begin
							out_d = {sr, sr};
							lsb_d = 1'b0;
							ocnt_d = '0;
							state_d = ST_DOUT;
						end else if (op == OPC_ERASE_SUSPEND) begin
							sref_d = erasing_q;
							sreq_d = wip_q && !erasing_q;
						end else if (!wip_q) begin
							case (op)
								OPC_WRITE_ENABLE: begin
									wel_d = 1'b1;
								end
								OPC_PMODE_READ: begin
									out_d = pmode_q;
									lsb_d = 1'b1;
									state_d = ST_DOUT;
								end
								OPC_OTP_READ, OPC_VOL_READ,
								OPC_PERS_READ: begin
									state_d = ST_ADDR;
								end
								OPC_OTP_PROGRAM, OPC_VOL_WRITE,
								OPC_PERS_PROGRAM: begin
									if (wel_q) begin
										state_d = ST_ADDR;
									end
								end
								OPC_PMODE_PROGRAM, OPC_PERS_ERASE: begin
									if (wel_q) begin
										state_d = ST_DIN;
									end
								end
								default: begin
									state_d = ST_IGNORE;
								end
							endcase
						end
					end
				end
				ST_ADDR: begin
					sh_d = shifted;
					cnt_d = cnt_q + 6'h1;
					if (cnt_q == ((opc_q == OPC_OTP_READ ||
						opc_q == OPC_OTP_PROGRAM) ?
						6'(OTP_ADDR_BITS - 1) : 6'(SECT_ADDR_BITS - 1))) begin
						cnt_d = '0;
						addr_d = (opc_q == OPC_OTP_READ ||
							opc_q == OPC_OTP_PROGRAM) ?
							{8'h00, shifted[23:0]} : shifted;
						ocnt_d = '0;
						lsb_d = 1'b0;
						case (opc_q)
							OPC_OTP_READ: begin
								state_d = ST_DUMMY;
							end
							OPC_VOL_READ: begin
								out_d = {2{vol_mem[shifted[SECTOR_SHIFT +:
									SIDX_W]]}};
								state_d = ST_DOUT;
							end
							OPC_PERS_READ: begin
								out_d = {2{pers_mem[shifted[SECTOR_SHIFT +:
									SIDX_W]]}};
								state_d = ST_DOUT;
							end
							default: begin
								state_d = ST_DIN;
							end
						endcase
					end
				end
				ST_DUMMY: begin
					cnt_d = cnt_q + 6'h1;
					// latency code is not consulted: one byte, always
					if (cnt_q == 6'(DUMMY_BITS - 1)) begin
						cnt_d = '0;
						out_d = {2{(addr_q < 32'(OTP_BYTES)) ? otp_old :
							OTP_UNDEFINED}};
						state_d = ST_DOUT;
					end
				end
				ST_DIN: begin
					if (cnt_q != 6'h3F) begin
						cnt_d = cnt_q + 6'h1;
					end
					if (opc_q == OPC_PMODE_PROGRAM) begin
						sh_d = {si, sh_q[31:1]};
					end else begin
						sh_d = shifted;
					end
					if (opc_q == OPC_OTP_PROGRAM &&
						cnt_q == 6'(BYTE_BITS - 1)) begin
						cnt_d = '0;
						otp_byte_evt = 1'b1;
						addr_d = {22'h0, 10'(addr_q[9:0] + 10'h1)};
						if (otp_locked_i) begin
							// ones into a locked region are harmless
							if (op != 8'hFF) begin
								perr_d = 1'b1;
							end
						end else begin
							otp_we = 1'b1;
							otp_wdata = otp_old & op;
						end
					end
				end
				default: begin
					state_d = state_q;
				end
			endcase
		end else if (sck_fall && state_q == ST_DOUT) begin
			so_d = lsb_q ? out_q[0] : out_q[15];
			out_d = lsb_q ? {out_q[0], out_q[15:1]} :
				{out_q[14:0], out_q[15]};
			ocnt_d = ocnt_q + 3'h1;
			if (ocnt_q == 3'h7) begin
				if (opc_q == OPC_OTP_READ) begin
					addr_d = addr_q + 32'h1;
					out_d = {otp_next, otp_next};
				end else if (opc_q == OPC_STATUS_READ) begin
					out_d = {sr, sr};
				end
			end
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state_q   <= ST_CMD;
			cnt_q     <= '0;
			sh_q      <= '0;
			opc_q     <= '0;
			addr_q    <= '0;
			out_q     <= '0;
			lsb_q     <= 1'b0;
			ocnt_q    <= '0;
			so_q      <= 1'b0;
			wel_q     <= 1'b0;
			wip_q     <= 1'b0;
			perr_q    <= 1'b0;
			erasing_q <= 1'b0;
			timer_q   <= '0;
			pmode_q   <= PMODE_RESET;
			sreq_q    <= 1'b0;
			sref_q    <= 1'b0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			sh_q      <= sh_d;
			opc_q     <= opc_d;
			addr_q    <= addr_d;
			out_q     <= out_d;
			lsb_q     <= lsb_d;
			ocnt_q    <= ocnt_d;
			so_q      <= so_d;
			wel_q     <= wel_d;
			wip_q     <= wip_d;
			perr_q    <= perr_d;
			erasing_q <= erasing_d;
			timer_q   <= timer_d;
			pmode_q   <= pmode_d;
			sreq_q    <= sreq_d;
			sref_q    <= sref_d;
		end
	end

	// ==========================================================
	// outputs
	assign so_o = so_q;
	assign so_oe_n_o = !(state_q == ST_DOUT && !cs_n);
	assign write_in_progress_flag_o = wip_q;
	assign write_enable_latch_o = wel_q;
	assign p_err_o = perr_q;
	assign bulk_erasing_o = erasing_q;
	assign suspend_req_o = sreq_q;
	assign suspend_refused_o = sref_q;
	assign protection_mode_register_o = pmode_q;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence s_otp_addr_done;
		state_q == ST_ADDR && opc_q == OPC_OTP_READ && sck_rise &&
			cnt_q == 6'(OTP_ADDR_BITS - 1);
	endsequence
	sequence s_dummy_done;
		state_q == ST_DUMMY && sck_rise && cnt_q == 6'(DUMMY_BITS - 1);
	endsequence

	property p_one_dummy_byte;
		s_otp_addr_done |=> state_q == ST_DUMMY;
	endproperty
	a_one_dummy_byte: assert property (p_one_dummy_byte)
		else $error("one-time read did not enter dummy byte");
	property p_dummy_to_data;
		s_dummy_done |=> state_q == ST_DOUT && !lsb_q;
	endproperty
	a_dummy_to_data: assert property (p_dummy_to_data)
		else $error("dummy byte did not lead to data");
	property p_wel_set;
		decode && op == OPC_WRITE_ENABLE && !wip_q |=> wel_q;
	endproperty
	a_wel_set: assert property (p_wel_set)
		else $error("write enable did not set latch");
	property p_no_wel_no_write;
		!wel_q |-> !otp_we && !vol_we && !pers_we && !start_op;
	endproperty
	a_no_wel_no_write: assert property (p_no_wel_no_write)
		else $error("write without latch");
	property p_start_busy;
		start_op |=> wip_q && wel_q ##1 wip_q;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("operation did not hold busy");
	property p_done_clears;
		wip_q && timer_q == '0 |=> !wip_q && !wel_q;
	endproperty
	a_done_clears: assert property (p_done_clears)
		else $error("completion did not clear flags");
	property p_locked_zero_err;
		otp_byte_evt && otp_locked_i && op != 8'hFF |-> !otp_we ##1 perr_q;
	endproperty
	a_locked_zero_err: assert property (p_locked_zero_err)
		else $error("locked zero program did not fail");
	property p_locked_ones_ok;
		otp_byte_evt && otp_locked_i && op == 8'hFF && !perr_q
			|=> !perr_q;
	endproperty
	a_locked_ones_ok: assert property (p_locked_ones_ok)
		else $error("ones into locked region raised error");
	property p_only_erased_bits;
		otp_we |-> (otp_wdata | otp_old) == otp_old;
	endproperty
	a_only_erased_bits: assert property (p_only_erased_bits)
		else $error("one-time bit went from zero to one");
	property p_pmode_lsb_first;
		sck_fall && state_q == ST_DOUT && opc_q == OPC_PMODE_READ
			|=> so_q == $past(out_q[0]);
	endproperty
	a_pmode_lsb_first: assert property (p_pmode_lsb_first)
		else $error("mode register not sent lsb first");
	property p_busy_ignores;
		decode && wip_q && op != OPC_STATUS_READ &&
			op != OPC_ERASE_SUSPEND |=> state_q == ST_IGNORE;
	endproperty
	a_busy_ignores: assert property (p_busy_ignores)
		else $error("command accepted while busy");
	property p_status_busy;
		decode && op == OPC_STATUS_READ |=> state_q == ST_DOUT;
	endproperty
	a_status_busy: assert property (p_status_busy)
		else $error("status read refused");
	property p_suspend_refused;
		decode && op == OPC_ERASE_SUSPEND && erasing_q
			|=> sref_q && !sreq_q;
	endproperty
	a_suspend_refused: assert property (p_suspend_refused)
		else $error("suspend not refused during bulk erase");
	property p_pmode_frame;
		start_op && opc_q == OPC_PMODE_PROGRAM
			|-> cnt_q == 6'(PMODE_BITS);
	endproperty
	a_pmode_frame: assert property (p_pmode_frame)
		else $error("mode program committed on bad frame");

endmodule

// file: src/osp_pkg.sv
// package of opcodes, field positions, reset values and timing counts
// assumes a serial flash command front end on one 200 MHz system clock
package osp_pkg;

	// ==========================================================
	// opcodes
	localparam logic [7:0] OPC_STATUS_READ    = 8'h05;
	localparam logic [7:0] OPC_WRITE_ENABLE   = 8'h06;
	localparam logic [7:0] OPC_OTP_PROGRAM    = 8'h42;
	localparam logic [7:0] OPC_OTP_READ       = 8'h4B;
	localparam logic [7:0] OPC_PMODE_READ     = 8'h2B;
	localparam logic [7:0] OPC_PMODE_PROGRAM  = 8'h2F;
	localparam logic [7:0] OPC_VOL_READ       = 8'hE0;
	localparam logic [7:0] OPC_VOL_WRITE      = 8'hE1;
	localparam logic [7:0] OPC_PERS_READ      = 8'hE2;
	localparam logic [7:0] OPC_PERS_PROGRAM   = 8'hE3;
	localparam logic [7:0] OPC_PERS_ERASE     = 8'hE4;
	localparam logic [7:0] OPC_ERASE_SUSPEND  = 8'h75;

	// ==========================================================
	// frame lengths in bits, one-time region size in bytes and its index width
	localparam int CMD_BITS       = 8;
	localparam int OTP_ADDR_BITS  = 24;
	localparam int SECT_ADDR_BITS = 32;
	localparam int DUMMY_BITS     = 8;
	localparam int PMODE_BITS     = 16;
	localparam int BYTE_BITS      = 8;
	localparam int OTP_BYTES      = 1024;
	localparam int OTP_INDEX_BITS = 10;

	// ==========================================================
	// status register one bit positions
	localparam int SR_WIP_BIT  = 0;
	localparam int SR_WEL_BIT  = 1;
	localparam int SR_PERR_BIT = 6;

	// ==========================================================
	// reset, erased, programmed and undefined read values
	localparam logic [15:0] PMODE_RESET     = 16'hFFFF;
	localparam logic [7:0]  VOL_RESET       = 8'hFF;
	localparam logic [7:0]  PERS_ERASED     = 8'hFF;
	localparam logic [7:0]  PERS_PROGRAMMED = 8'h00;
	localparam logic [7:0]  OTP_ERASED      = 8'hFF;
	localparam logic [7:0]  OTP_UNDEFINED   = 8'hFF;

	// ==========================================================
	// timing
	localparam int CLOCK_PERIOD_PS = 5000;
	localparam int PROG_TIME_NS    = 2000;
	localparam int ERASE_TIME_NS   = 100000;
	localparam int PROG_CYCLES_DEF =
		(PROG_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int ERASE_CYCLES_DEF =
		(ERASE_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int TIMER_BITS = 24;

	// ==========================================================
	// frame states
	typedef enum logic [5:0] {
		ST_CMD    = 6'b000001,
		ST_ADDR   = 6'b000010,
		ST_DUMMY  = 6'b000100,
		ST_DIN    = 6'b001000,
		ST_DOUT   = 6'b010000,
		ST_IGNORE = 6'b100000
	} osp_state_type;

endpackage

// file: tb/osp_host.sv
// host serial controller model driving select, clock and data in
// assumes a 200 MHz system clock; serial clock stays low between frames
`timescale 1ns/10ps
module osp_host (
	// clock
	input  wire logic clock_i,
	// serial pins
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      si_o,
	input  wire logic so_i,
	input  wire logic so_oe_n_i
);
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
	end

	// ==========================================================
	// one frame: nt bits out msb first, then nr bits sampled
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	// six clocks per half period keeps data clear of the synchronisers
	task automatic frame(input logic [63:0] tx, input int nt, input int nr,
			output logic [63:0] rx);
		rx = '0;
		cs_n_o = 1'b0;
		for (int i = 0; i < nt + nr; i++) begin
			si_o = (i < nt) ? tx[nt-1-i] : ~si_o;
			tick(6);
			sck_o = 1'b1;
			if (i >= nt)
				rx = {rx[62:0], so_oe_n_i ? 1'bx : so_i};
			tick(6);
			sck_o = 1'b0;
		end
		tick(6);
		cs_n_o = 1'b1;
		si_o = ~si_o;
		tick(12);
	endtask
endmodule

// file: tb/osp_cmd_tb.sv
// self-checking bench for the protection and one-time command block
// assumes the host model in osp_host, a shortened erase time and a lengthened program time
`timescale 1ns/10ps
module osp_cmd_tb;
	import osp_pkg::*;
	logic        clock_i, reset_i, cs_n, sck, si, so, so_oe_n;
	logic        otp_locked_i, p_err_clear_i, write_in_progress_flag, write_enable_latch, perr, bulk;
	logic [15:0] pmode_o, pmode_m, w, r;
	logic [63:0] rx;
	logic [7:0]  vol_m [256];
	logic [7:0]  pers_m [256];
	logic [7:0]  otp_m [1024];
	logic [7:0]  s, d;
	logic [9:0]  a;
	logic        perr_m, wel_m, sref, sreq;
	int          failures, n_tests, cyc, refused, asked;

	osp_cmd #(.PROG_CYCLES(600), .ERASE_CYCLES(1200)) dut (
		.clock_i(clock_i), .reset_i(reset_i), .cs_n_i(cs_n),
		.sck_i(sck), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n),
		.otp_locked_i(otp_locked_i), .p_err_clear_i(p_err_clear_i),
		.write_in_progress_flag_o(write_in_progress_flag), .write_enable_latch_o(write_enable_latch),
		.p_err_o(perr), .bulk_erasing_o(bulk), .suspend_req_o(sreq),
		.suspend_refused_o(sref), .protection_mode_register_o(pmode_o));
	osp_host host (.clock_i(clock_i), .cs_n_o(cs_n), .sck_o(sck),
		.si_o(si), .so_i(so), .so_oe_n_i(so_oe_n));

	// ==========================================================
	// clock, timeout, pulse catcher
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (sref === 1'b1)
			refused++;
		if (sreq === 1'b1)
			asked++;
		if (cyc == 60000) begin
			failures++;
			finish_test();
		end
	end

	// ==========================================================
	// compares and command helpers
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_pin(input logic [15:0] got, input logic [15:0] exp);
		chk(got, exp);
	endtask
	task wr(input logic [63:0] tx, input int nt, input logic go);
		host.frame(OPC_WRITE_ENABLE, 8, 0, rx);
		chk_pin(write_enable_latch, 1'b1);
		wel_m = !go;
		host.frame(tx, nt, 0, rx);
		chk_pin(write_in_progress_flag, go);
		if (go) begin
			host.frame(OPC_STATUS_READ, 8, 8, rx);
			chk(rx[1:0], 2'b11);
		end
	endtask
	task done;
		int i;
		i = 0;
		rx = 64'h1;
		while (rx[0] !== 1'b0 && i < 30) begin
			host.frame(OPC_STATUS_READ, 8, 8, rx);
			i++;
		end
		chk(rx, {perr_m, 4'h0, wel_m, 1'b0});
		chk_pin(write_enable_latch, wel_m);
	endtask
	task finish_test;
		if (failures == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		reset_i = 1'b1;
		otp_locked_i = 1'b0;
		p_err_clear_i = 1'b0;
		perr_m = 1'b0;
		wel_m = 1'b0;
		pmode_m = 16'hFFFF;
		foreach (vol_m[i]) begin
			vol_m[i] = 8'hFF;
			pers_m[i] = 8'hFF;
		end
		foreach (otp_m[i])
			otp_m[i] = 8'hFF;
		void'($urandom(32'h22C222D5));
		repeat (12) @(posedge clock_i);
		#1 reset_i = 1'b0;
		repeat (3) @(posedge clock_i);
		#1;
		chk_pin(pmode_o, pmode_m);
		host.frame(OPC_STATUS_READ, 8, 8, rx);
		chk(rx, 64'h0);
		// write without the latch must leave the byte alone
		s = 8'($urandom);
		host.frame({OPC_VOL_WRITE, 6'h0, s, 18'h0, 8'h00}, 48, 0, rx);
		host.frame({OPC_VOL_READ, 6'h0, s, 18'h0}, 40, 16, rx);
		chk(rx, {2{vol_m[s]}});
		host.frame(OPC_WRITE_ENABLE, 8, 0, rx);
		host.frame(OPC_STATUS_READ, 8, 8, rx);
		chk(rx, 64'h2);
		// volatile bytes at both ends of the sector range
		for (int k = 0; k < 3; k++) begin
			s = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
			d = 8'($urandom);
			wr({OPC_VOL_WRITE, 6'h0, s, 18'h0, d}, 48, 1'b1);
			vol_m[s] = d;
			done();
			wr({OPC_VOL_WRITE, 6'h0, s, 18'h0, ~d, 1'b0}, 49, 1'b0);
			done();
			host.frame({OPC_VOL_READ, 6'h0, s, 18'h0}, 40, 16, rx);
			chk(rx, {2{vol_m[s]}});
		end
		// protection mode register, lsb first, twice per read
		for (int k = 0; k < 2; k++) begin
			w = 16'($urandom);
			r = {<<{w}};
			wr({OPC_PMODE_PROGRAM, r}, 24, 1'b1);
			pmode_m &= w;
			done();
			wr({OPC_PMODE_PROGRAM, r, 1'b0}, 25, 1'b0);
			done();
			chk_pin(pmode_o, pmode_m);
			r = {<<{pmode_m}};
			host.frame(OPC_PMODE_READ, 8, 32, rx);
			chk(rx, {r, r});
		end
		// persistent bits: program, bad erase frame, real erase
		s = 8'($urandom);
		wr({OPC_PERS_PROGRAM, 6'h0, s, 18'h0, 1'b0}, 41, 1'b0);
		done();
		wr({OPC_PERS_PROGRAM, 6'h0, s, 18'h0}, 40, 1'b1);
		// an ordinary program may be suspended, unlike the bulk erase
		host.frame(OPC_ERASE_SUSPEND, 8, 0, rx);
		chk(asked, 1);
		pers_m[s] = 8'h00;
		done();
		wr({OPC_PERS_ERASE, 1'b0}, 9, 1'b0);
		done();
		host.frame({OPC_PERS_READ, 6'h0, s, 18'h0}, 40, 16, rx);
		chk(rx, {2{pers_m[s]}});
		refused = 0;
		wr(OPC_PERS_ERASE, 8, 1'b1);
		chk_pin(bulk, 1'b1);
		host.frame(OPC_ERASE_SUSPEND, 8, 0, rx);
		chk(refused, 1);
		chk(asked, 1);
		done();
		pers_m[s] = 8'hFF;
		chk_pin(bulk, 1'b0);
		host.frame({OPC_PERS_READ, 6'h0, s, 18'h0}, 40, 8, rx);
		chk(rx, pers_m[s]);
		// one-time region: repeat programming ands, then locked
		a = 10'($urandom);
		for (int k = 0; k < 2; k++) begin
			d = 8'($urandom);
			wr({OPC_OTP_PROGRAM, 14'h0, a, d}, 40, 1'b1);
			otp_m[a] &= d;
			done();
		end
		host.frame({OPC_OTP_READ, 14'h0, a, 8'h00}, 40, 8, rx);
		chk(rx, otp_m[a]);
		// last byte, then no wrap back to the first
		host.frame({OPC_OTP_READ, 24'h0003FF, 8'h00}, 40, 16, rx);
		chk(rx, {otp_m[1023], OTP_UNDEFINED});
		otp_locked_i = 1'b1;
		wr({OPC_OTP_PROGRAM, 14'h0, a, 8'hFF}, 40, 1'b1);
		done();
		chk_pin(perr, 1'b0);
		wr({OPC_OTP_PROGRAM, 14'h0, a, 8'h00}, 40, 1'b1);
		perr_m = 1'b1;
		done();
		chk_pin(perr, 1'b1);
		host.frame({OPC_OTP_READ, 14'h0, a, 8'h00}, 40, 8, rx);
		chk(rx, otp_m[a]);
		p_err_clear_i = 1'b1;
		@(posedge clock_i);
		#1 p_err_clear_i = 1'b0;
		@(posedge clock_i);
		#1;
		chk_pin(perr, 1'b0);
		finish_test();
	end
endmodule
